// File: logic/buck_setting_pkg.sv
// constants, types and the code-to-voltage table shared by the buck setting register bank
package buck_setting_pkg;

  // ****************************************
  // register bus and map
  // ****************************************
  localparam int           REG_ADDR_W    = 8;
  localparam int           REG_DATA_W    = 8;
  localparam int           NUM_BUCK      = 2;
  localparam logic [7:0]   ADDR_BUCK_ONE = 8'h16;
  localparam logic [7:0]   ADDR_BUCK_TWO = 8'h17;
  localparam logic [7:0]   RST_BUCK_ONE  = 8'hab;
  localparam logic [7:0]   RST_BUCK_TWO  = 8'hb2;

  // ****************************************
  // field layout
  // ****************************************
  localparam int           PULSE_SKIP_BIT = 7;
  localparam int           RSVD_BIT       = 6;
  localparam int           CODE_MSB       = 5;
  localparam int           CODE_W         = 6;
  localparam logic         RSVD_VALUE     = 1'b0;

  // ****************************************
  // code-to-voltage table, in millivolts
  // ****************************************
  localparam int           MV_W          = 11;
  localparam int           MV_BASE       = 850;
  localparam int           MV_FINE_STEP  = 10;
  localparam int           COARSE_CODE   = 32'h32;
  localparam int           MV_AT_COARSE  = 1350;
  localparam int           MV_COARSE_STEP = 25;

  // ****************************************
  // timing
  // ****************************************
  localparam int           BLANK_TIME_MS = 5;
  localparam int           CLK_FREQ_KHZ  = 125000;
  localparam int           BLANK_CYCLES  = BLANK_TIME_MS * CLK_FREQ_KHZ;

  typedef struct packed {
    logic              pulse_skip;
    logic [CODE_W-1:0] code;
  } buck_cfg_s;

  typedef logic [MV_W-1:0] millivolt_t;

  function automatic millivolt_t code_to_mv(input logic [CODE_W-1:0] code);
    int c;
    c = int'(code);
    if (c <= COARSE_CODE) begin
      code_to_mv = MV_W'(MV_BASE + MV_FINE_STEP * c);
    end else begin
      code_to_mv = MV_W'(MV_AT_COARSE + MV_COARSE_STEP * (c - COARSE_CODE));
    end
  endfunction : code_to_mv

endpackage : buck_setting_pkg

// File: logic/buck_voltage_setting_regs.sv
// setting registers, monitor blanking and go-gated voltage apply for two buck converters
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps

// How it works
// - first code 0 is 0.850 V, 10 mV steps to 32h, 25 mV to 3Fh; reset 2Bh
// - second converter register sits at 0x17 and resets to 0xB2
// - a write lands only while the password mechanism reports unlocked
// - every accepted write blanks that converter's voltage fault monitoring for 5 ms
// - a new code reaches the converter only on a go or go-disable pulse
// - bit 7 enables light-load pulse skip when 1, forced PWM when 0; resets to 1
// - second code in bits 5..0, read/write, resets 32h, same table as first
// - first register at 0x16 gets the same go gating and 5 ms blanking
module buck_voltage_setting_regs
  import buck_setting_pkg::*;
#(
  parameter int BLANK_CYCLES_P = BLANK_CYCLES
) (
  input  wire logic                                  sys_clk,
  input  wire logic                                  rst_n,
  input  wire logic [REG_ADDR_W-1:0]                 reg_addr,
  input  wire logic [REG_DATA_W-1:0]                 reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output logic      [REG_DATA_W-1:0]                 reg_rdata,
  input  wire logic                                  write_unlocked,
  output logic                                       unlock_consumed,
  input  wire logic                                  apply_go,
  input  wire logic                                  apply_on_disable_bit,
  input  wire logic [NUM_BUCK-1:0]                   ov_fault_raw,
  input  wire logic [NUM_BUCK-1:0]                   uv_fault_raw,
  output logic      [NUM_BUCK-1:0]                   ov_fault,
  output logic      [NUM_BUCK-1:0]                   uv_fault,
  output logic      [NUM_BUCK-1:0]                   monitor_blank,
  output buck_cfg_s [NUM_BUCK-1:0]                   active_cfg,
  output millivolt_t [NUM_BUCK-1:0]                  target_mv
);

  localparam int CNT_W = $clog2(BLANK_CYCLES_P + 1);
  localparam logic [CNT_W-1:0] BLANK_LOAD = CNT_W'(BLANK_CYCLES_P);
  localparam logic [CNT_W-1:0] CNT_ONE    = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO   = '0;

  localparam logic [NUM_BUCK-1:0][REG_ADDR_W-1:0] BUCK_ADDR = {ADDR_BUCK_TWO, ADDR_BUCK_ONE};
  localparam logic [NUM_BUCK-1:0][REG_DATA_W-1:0] BUCK_RST  = {RST_BUCK_TWO, RST_BUCK_ONE};

  // ****************************************
  // write decode
  // ****************************************
  logic      [NUM_BUCK-1:0]             wr_hit;
  logic      [NUM_BUCK-1:0]             wr_ok;
  buck_cfg_s [NUM_BUCK-1:0]             setting;
  logic      [NUM_BUCK-1:0][CNT_W-1:0]  blank_cnt;
  logic      [NUM_BUCK-1:0]             ov_sync1;
  logic      [NUM_BUCK-1:0]             ov_sync2;
  logic      [NUM_BUCK-1:0]             uv_sync1;
  logic      [NUM_BUCK-1:0]             uv_sync2;
  logic                                 apply_pulse;
  logic      [REG_DATA_W-1:0]           next_rdata;

  assign apply_pulse     = apply_go | apply_on_disable_bit;
  // tells the password logic to re-arm; each protected write needs a fresh unlock
  assign unlock_consumed = |wr_ok;

  genvar i;
  generate
    for (i = 0; i < NUM_BUCK; i++) begin : g_buck

      assign wr_hit[i] = reg_wr && (reg_addr == BUCK_ADDR[i]);
      assign wr_ok[i]  = wr_hit[i] && write_unlocked;

      // ****************************************
      // setting register
      // ****************************************
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          setting[i].pulse_skip <= BUCK_RST[i][PULSE_SKIP_BIT];
          setting[i].code       <= BUCK_RST[i][CODE_MSB:0];
        end else if (wr_ok[i]) begin
          // bit 6 has no storage, so a write to it is simply dropped
          setting[i].pulse_skip <= reg_wdata[PULSE_SKIP_BIT];
          setting[i].code       <= reg_wdata[CODE_MSB:0];
        end
      end

      // ****************************************
      // monitor blanking
      // ****************************************
      // a write during blanking restarts the full interval
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          blank_cnt[i] <= CNT_ZERO;
        end else if (wr_ok[i]) begin
          blank_cnt[i] <= BLANK_LOAD;
        end else if (blank_cnt[i] != CNT_ZERO) begin
          blank_cnt[i] <= blank_cnt[i] - CNT_ONE;
        end
      end

      assign monitor_blank[i] = (blank_cnt[i] != CNT_ZERO);

      // monitor comparators are asynchronous to sys_clk
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          ov_sync1[i] <= 1'b0;
          ov_sync2[i] <= 1'b0;
          uv_sync1[i] <= 1'b0;
          uv_sync2[i] <= 1'b0;
        end else begin
          ov_sync1[i] <= ov_fault_raw[i];
          ov_sync2[i] <= ov_sync1[i];
          uv_sync1[i] <= uv_fault_raw[i];
          uv_sync2[i] <= uv_sync1[i];
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          ov_fault[i] <= 1'b0;
          uv_fault[i] <= 1'b0;
        end else begin
          // the write itself masks too, else a standing fault leaks one cycle past the write
          ov_fault[i] <= ov_sync2[i] && !monitor_blank[i] && !wr_ok[i];
          uv_fault[i] <= uv_sync2[i] && !monitor_blank[i] && !wr_ok[i];
        end
      end

      // ****************************************
      // applied setting
      // ****************************************
      // mode bit follows the register one clock later without go; only the voltage waits for go
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          active_cfg[i].pulse_skip <= BUCK_RST[i][PULSE_SKIP_BIT];
          active_cfg[i].code       <= BUCK_RST[i][CODE_MSB:0];
        end else begin
          active_cfg[i].pulse_skip <= setting[i].pulse_skip;
          if (apply_pulse) begin
            active_cfg[i].code <= setting[i].code;
          end
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          target_mv[i] <= code_to_mv(BUCK_RST[i][CODE_MSB:0]);
        end else begin
          target_mv[i] <= code_to_mv(active_cfg[i].code);
        end
      end

      // ****************************************
      // checks per converter
      // ****************************************
      AST_LOCKED_WRITE_IGNORED: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wr_hit[i] && !write_unlocked) |=> $stable(setting[i]))
        else $error("locked write changed a setting");

      AST_WRITE_STORES: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        wr_ok[i] |=> (setting[i].code == $past(reg_wdata[CODE_MSB:0]))
                  && (setting[i].pulse_skip == $past(reg_wdata[PULSE_SKIP_BIT])))
        else $error("accepted write not stored");

      AST_BLANK_START: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        wr_ok[i] |=> (monitor_blank[i] && !ov_fault[i] && !uv_fault[i]) [*4])
        else $error("blanking or fault masking missing after write");

      AST_BLANK_END: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (blank_cnt[i] == CNT_ONE && !wr_ok[i]) |=> !monitor_blank[i])
        else $error("blanking outlasted its interval");

      AST_BLANK_LENGTH: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        wr_ok[i] |=> (blank_cnt[i] == BLANK_LOAD))
        else $error("blank interval not loaded with full count");

      AST_HOLD_UNTIL_GO: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !apply_pulse |=> $stable(active_cfg[i].code))
        else $error("voltage changed without go");

      AST_GO_APPLIES: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        apply_pulse |=> (active_cfg[i].code == $past(setting[i].code)))
        else $error("go did not apply written code");

      AST_MV_TABLE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $changed(active_cfg[i].code) |=> (target_mv[i] == code_to_mv($past(active_cfg[i].code))))
        else $error("target voltage does not match table");

      AST_PULSE_SKIP: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        wr_ok[i] |=> ##1 (active_cfg[i].pulse_skip == $past(reg_wdata[PULSE_SKIP_BIT], 2)))
        else $error("mode bit not passed to converter");

      AST_FAULT_MASKED: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (monitor_blank[i] || wr_ok[i]) |=> (!ov_fault[i] && !uv_fault[i]))
        else $error("fault reported during blanking");

      AST_FAULT_PASSES: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!monitor_blank[i] && !wr_ok[i]) |=> (ov_fault[i] == $past(ov_sync2[i]))
                                          && (uv_fault[i] == $past(uv_sync2[i])))
        else $error("fault not passed outside blanking");

      AST_BLANK_ONLY_ON_WRITE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!monitor_blank[i] && !wr_ok[i]) |=> !monitor_blank[i])
        else $error("blanking started without a write");

      AST_SKIP_FOLLOWS: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (setting[i].pulse_skip != active_cfg[i].pulse_skip) |=>
          (active_cfg[i].pulse_skip == $past(setting[i].pulse_skip)))
        else $error("mode bit held back from converter");

      AST_TARGET_AFTER_GO: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        apply_pulse |=> ##1 (target_mv[i] == code_to_mv($past(setting[i].code, 2))))
        else $error("target voltage not updated after go");

      COV_BLANK_EXPIRES: cover property (
        @(posedge sys_clk) disable iff (!rst_n)
        $fell(monitor_blank[i]));

      COV_FAULT_UNMASKED: cover property (
        @(posedge sys_clk) disable iff (!rst_n)
        $fell(monitor_blank[i]) ##[1:4] ov_fault[i]);

      COV_WRITE_THEN_GO: cover property (
        @(posedge sys_clk) disable iff (!rst_n)
        wr_ok[i] ##[1:20] apply_pulse);

      COV_LOCKED_WRITE: cover property (
        @(posedge sys_clk) disable iff (!rst_n)
        wr_hit[i] && !write_unlocked);

    end
  endgenerate

  // ****************************************
  // read port
  // ****************************************
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      for (int k = 0; k < NUM_BUCK; k++) begin
        if (reg_addr == BUCK_ADDR[k]) begin
          next_rdata[PULSE_SKIP_BIT] = setting[k].pulse_skip;
          next_rdata[RSVD_BIT]       = RSVD_VALUE;
          next_rdata[CODE_MSB:0]     = setting[k].code;
        end
      end
    end
  end

  // data stands only in the cycle after the read strobe; unmapped reads return zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  AST_RESERVED_ZERO: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    reg_rd |=> (reg_rdata[RSVD_BIT] == RSVD_VALUE))
    else $error("reserved bit read as one");

  AST_READBACK_TWO: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == ADDR_BUCK_TWO) |=>
      (reg_rdata == {$past(setting[1].pulse_skip), RSVD_VALUE, $past(setting[1].code)}))
    else $error("second register readback wrong");

  AST_READ_ONE_CYCLE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !reg_rd |=> (reg_rdata == '0))
    else $error("read data outside its cycle");

  AST_READBACK_ONE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == ADDR_BUCK_ONE) |=>
      (reg_rdata == {$past(setting[0].pulse_skip), RSVD_VALUE, $past(setting[0].code)}))
    else $error("first register readback wrong");

  AST_UNMAPPED_ZERO: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr != ADDR_BUCK_ONE && reg_addr != ADDR_BUCK_TWO) |=> (reg_rdata == '0))
    else $error("unmapped read returned data");

  AST_UNMAPPED_WRITE_IGNORED: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr != ADDR_BUCK_ONE && reg_addr != ADDR_BUCK_TWO) |=> $stable(setting))
    else $error("unmapped write changed a setting");

  COV_READ_TWO: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_BUCK_TWO);

endmodule : buck_voltage_setting_regs

// File: bench/tb.sv
// self-checking bench for the buck setting register bank
`timescale 1ns/1ps
module tb;
  import buck_setting_pkg::*;

  // ****************************************
  // signals and design under test
  // ****************************************
  localparam int BLANK_N = 16;

  logic                          sys_clk = 1'b0;
  logic                          rst_n;
  logic       [REG_ADDR_W-1:0]   reg_addr;
  logic       [REG_DATA_W-1:0]   reg_wdata;
  logic                          reg_wr;
  logic                          reg_rd;
  logic       [REG_DATA_W-1:0]   reg_rdata;
  logic                          write_unlocked;
  logic                          unlock_consumed;
  logic                          apply_go;
  logic                          apply_on_disable_bit;
  logic       [NUM_BUCK-1:0]     ov_fault_raw;
  logic       [NUM_BUCK-1:0]     uv_fault_raw;
  logic       [NUM_BUCK-1:0]     ov_fault;
  logic       [NUM_BUCK-1:0]     uv_fault;
  logic       [NUM_BUCK-1:0]     monitor_blank;
  buck_cfg_s  [NUM_BUCK-1:0]     active_cfg;
  millivolt_t [NUM_BUCK-1:0]     target_mv;
  int                            error_cnt = 0;
  int                            n_checks = 0;
  logic                          uc;
  logic       [7:0]              d;
  logic       [5:0]              prev;
  logic       [5:0]              codes [6] = '{6'h00, 6'h01, 6'h2b, 6'h32, 6'h33, 6'h3f};

  always #4 sys_clk = ~sys_clk;

  buck_voltage_setting_regs #(.BLANK_CYCLES_P(BLANK_N)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .write_unlocked(write_unlocked), .unlock_consumed(unlock_consumed),
    .apply_go(apply_go), .apply_on_disable_bit(apply_on_disable_bit), .ov_fault_raw(ov_fault_raw),
    .uv_fault_raw(uv_fault_raw), .ov_fault(ov_fault), .uv_fault(uv_fault), .monitor_blank(monitor_blank),
    .active_cfg(active_cfg), .target_mv(target_mv)
  );

  // ****************************************
  // access tasks
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // unlock is only offered beside the write itself, so a lingering level cannot hide a lock fault
  task automatic wr(input logic [7:0] a, input logic [7:0] dat, input logic unl);
    @(posedge sys_clk);
    reg_wr         <= 1'b1;
    reg_addr       <= a;
    reg_wdata      <= dat;
    write_unlocked <= unl;
    #1;
    uc = unlock_consumed;
    @(posedge sys_clk);
    reg_wr         <= 1'b0;
    write_unlocked <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    dat = reg_rdata;
  endtask : rd

  task automatic go(input logic dis);
    @(posedge sys_clk);
    if (dis) begin
      apply_on_disable_bit <= 1'b1;
    end else begin
      apply_go <= 1'b1;
    end
    @(posedge sys_clk);
    apply_go             <= 1'b0;
    apply_on_disable_bit <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : go

  function automatic logic [15:0] mv(input logic [5:0] c);
    int k;
    k = int'(c);
    return (k <= 32'h32) ? 16'(850 + 10 * k) : 16'(1350 + 25 * (k - 32'h32));
  endfunction : mv

  // raw faults are already high when this starts, so any leak through the mask shows
  task automatic blank_run(input int idx);
    int   n;
    logic seen;
    n    = 0;
    seen = 1'b0;
    #1;
    while (monitor_blank[idx] === 1'b1 && n < 40) begin
      seen = seen | ov_fault[idx] | uv_fault[idx];
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 40) begin
      error_cnt++;
      report_and_stop();
    end
    check("blank cycles", 16'(n), 16'(BLANK_N));
    check("fault masked", {15'h0, seen}, 16'h0);
    repeat (2) @(posedge sys_clk);
    #1;
    check("fault after blank", {14'h0, ov_fault[idx], uv_fault[idx]}, 16'h3);
  endtask : blank_run

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, write_unlocked} = '0;
    {apply_go, apply_on_disable_bit, ov_fault_raw, uv_fault_raw} = '0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h16, d);
    check("one reset", 16'(d), 16'h00ab);
    rd(8'h17, d);
    check("two reset", 16'(d), 16'h00b2);
    check("one mv reset", 16'(target_mv[0]), 16'd1280);
    check("two mv reset", 16'(target_mv[1]), 16'd1350);
    rd(8'h20, d);
    check("unmapped read", 16'(d), 16'h0);
    wr(8'h16, 8'h05, 1'b0);
    check("locked consume", 16'(uc), 16'h0);
    rd(8'h16, d);
    check("locked keep", 16'(d), 16'h00ab);
    check("locked blank", 16'(monitor_blank), 16'h0);
    @(posedge sys_clk);
    ov_fault_raw <= 2'b01;
    uv_fault_raw <= 2'b01;
    wr(8'h16, 8'h45, 1'b1);
    check("open consume", 16'(uc), 16'h1);
    blank_run(0);
    check("one skip", 16'(active_cfg[0].pulse_skip), 16'h0);
    check("one code held", 16'(active_cfg[0].code), 16'h2b);
    check("one mv held", 16'(target_mv[0]), 16'd1280);
    @(posedge sys_clk);
    ov_fault_raw <= 2'b10;
    uv_fault_raw <= 2'b10;
    rd(8'h16, d);
    check("one readback", 16'(d), 16'h0005);
    go(1'b0);
    check("one mv go", 16'(target_mv[0]), 16'd900);
    wr(8'h17, 8'h32, 1'b1);
    blank_run(1);
    @(posedge sys_clk);
    ov_fault_raw <= 2'b00;
    uv_fault_raw <= 2'b00;
    prev = 6'h32;
    for (int i = 0; i < 6; i++) begin
      wr(8'h17, {i[0], 1'b1, codes[i]}, 1'b1);
      rd(8'h17, d);
      check("two readback", 16'(d), 16'({i[0], 1'b0, codes[i]}));
      check("two code held", 16'(active_cfg[1].code), 16'(prev));
      go(i[0]);
      check("two code go", 16'(active_cfg[1].code), 16'(codes[i]));
      check("two skip", 16'(active_cfg[1].pulse_skip), 16'(i[0]));
      check("two mv", 16'(target_mv[1]), mv(codes[i]));
      prev = codes[i];
    end
    report_and_stop();
  end

endmodule : tb
